/* File: include/aad_pkg.sv */
// Shared constants of the record-path decimator.
// Assumes nothing beyond a SystemVerilog compiler.
package aad_pkg;
   localparam int OSR = 128;
   localparam int CIC_RATIO = 16;
   localparam int CIC_ORDER = 3;
   localparam int HB_STAGES = 3;
   localparam int HB_TAPS = 7;
   localparam int DATA_W = 24;
   localparam int CIC_W = 16;
   localparam int CIC_SHIFT = 10;
   localparam int WORD_LEN = 20;
   localparam int HPF_SHIFT = 12;
   localparam int MUTE_FRAMES_DC_OFF = 1024;
   localparam int MUTE_FRAMES_DC_ON = 12288;
   localparam int FRAME_CNT_W = 14;
   localparam int SAMPLE_W = 2 * WORD_LEN;
   localparam int BUF_DEPTH = 2;
   localparam logic [3:0] CIC_LAST = 4'hf;
endpackage

/* File: include/aad_stream_if.sv */
// Valid/ready stream carrying one stereo sample pair.
// Source drives valid and data, sink drives ready.
`timescale 1ns/10ps
interface aad_stream_if #(parameter int WIDTH = 40);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: logic/aad_pair_buf.sv */
// Two-entry buffer for stereo sample pairs.
// Assumes both sides on core_clk; synchronous active-high reset.
`timescale 1ns/10ps
module aad_pair_buf
   import aad_pkg::*;
#(
   parameter int DEPTH = BUF_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Streams
   aad_stream_if.snk fill,
   aad_stream_if.src drain
);
   localparam int PW = $clog2(DEPTH);
   logic [SAMPLE_W-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg;
   logic [PW-1:0] rd_reg;
   logic [PW:0] cnt_reg;
   wire push = fill.valid && fill.ready;
   wire pop = drain.valid && drain.ready;
   wire [PW-1:0] wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
   wire [PW-1:0] rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;

   assign fill.ready = (cnt_reg != (PW + 1)'(DEPTH));
   assign drain.valid = (cnt_reg != '0);
   assign drain.data = mem_reg[rd_reg];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= fill.data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_next;
         end
         if (pop) begin
            rd_reg <= rd_next;
         end
         cnt_reg <= cnt_reg + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end
endmodule

/* File: logic/aad_decimator.sv */
// Stereo sigma-delta decimator with DC filter and slave serial output.
// Assumes modulator bits, bit clock and word select are synchronous to core_clk.
// What the host must do and what this block does
// [RULE1] Host supplies master timing locked to the serial port signals; device is slave.
// [RULE2] Host keeps bit clock at most 128 times the word select rate.
// [RULE3] Host changes word select only on a falling bit clock edge.
// [RULE4] Host keeps the frame rate between 8 kHz and 55 kHz.
// [RULE5] In justified formats word select has equal high and low halves.
// [RULE6] Accept one bitstream per channel at 128 times the sample rate.
// [RULE7] Front-end gain selectable between 0 dB and 6 dB by one input.
// [RULE8] Decimate to one sample per frame through exactly two cascaded stages.
// [RULE9] First stage is third-order sinc, decimating by sixteen.
// [RULE10] Second stage is three half-band FIR filters, each halving the rate.
// [RULE11] Flat pass band, stop band beyond 0.55 fs, overall DC gain -1.16 dB.
// [RULE12] Optional IIR high-pass after decimation, enabled by a control setting.
// [RULE13] High-pass has unity pass band and strong rejection at DC.
// [RULE14] Serial output held low for 1024 frames, or 12288 with DC removal.
// [RULE15] Emit I2S or left-justified words up to 20 bits, left and right multiplexed.
// [RULE16] Capture both channels from one instant, shift MSB first on bit clock.
`timescale 1ns/10ps
module aad_decimator
   import aad_pkg::*;
#(
   parameter int MUTE_OFF_FRAMES = MUTE_FRAMES_DC_OFF,
   parameter int MUTE_ON_FRAMES = MUTE_FRAMES_DC_ON
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Modulator bitstreams
   input wire logic mod_strobe,
   input wire logic mod_bit_left,
   input wire logic mod_bit_right,
   // Static controls
   input wire logic gain_select_pin,
   input wire logic hpf_enable,
   input wire logic fmt_i2s,
   // Serial audio port
   input wire logic bck,
   input wire logic ws,
   output logic serial_sample_out
);
   // Sinc stage: integrators at modulator rate, combs every sixteenth bit
   logic [3:0] dec_cnt_reg;
   logic cic_valid_reg;
   logic signed [CIC_W-1:0] integ_reg [2][CIC_ORDER];
   logic signed [CIC_W-1:0] comb_dly_reg [2][CIC_ORDER];
   logic signed [DATA_W-1:0] cic_out_reg [2];
   wire cic_dump = mod_strobe && (dec_cnt_reg == CIC_LAST);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         dec_cnt_reg <= '0;
         cic_valid_reg <= 1'b0;
      end else begin
         if (mod_strobe) begin
            dec_cnt_reg <= dec_cnt_reg + 1'b1; // [RULE9]
         end
         cic_valid_reg <= cic_dump;
      end
   end

   // Half-band chain taps and handshake per channel and stage
   logic signed [DATA_W-1:0] hb_tap_reg [2][HB_STAGES][HB_TAPS];
   logic hb_phase_reg [2][HB_STAGES];
   logic hb_valid_reg [2][HB_STAGES];
   logic signed [DATA_W-1:0] hb_out_reg [2][HB_STAGES];

   genvar ch, st, k;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         wire mod_bit = (ch == 0) ? mod_bit_left : mod_bit_right;
         wire signed [CIC_W-1:0] in_val = mod_bit ? CIC_W'(1) : -CIC_W'(1); // [RULE6]
         wire signed [CIC_W-1:0] c1 = integ_reg[ch][2] - comb_dly_reg[ch][0];
         wire signed [CIC_W-1:0] c2 = c1 - comb_dly_reg[ch][1];
         wire signed [CIC_W-1:0] c3 = c2 - comb_dly_reg[ch][2];

         always_ff @(posedge core_clk) begin
            if (srst) begin
               integ_reg[ch] <= '{default: '0};
               comb_dly_reg[ch] <= '{default: '0};
               cic_out_reg[ch] <= '0;
            end else if (mod_strobe) begin
               integ_reg[ch][0] <= integ_reg[ch][0] + in_val; // [RULE9]
               integ_reg[ch][1] <= integ_reg[ch][1] + integ_reg[ch][0];
               integ_reg[ch][2] <= integ_reg[ch][2] + integ_reg[ch][1];
               if (cic_dump) begin
                  comb_dly_reg[ch][0] <= integ_reg[ch][2];
                  comb_dly_reg[ch][1] <= c1;
                  comb_dly_reg[ch][2] <= c2;
                  cic_out_reg[ch] <= DATA_W'(c3) <<< CIC_SHIFT; // [RULE8]
               end
            end
         end

         for (st = 0; st < HB_STAGES; st++) begin : g_hb
            // Previous stage index is clamped so stage 0 never names index -1
            localparam int PREV = (st == 0) ? 0 : st - 1;
            wire in_valid = (st == 0) ? cic_valid_reg : hb_valid_reg[ch][PREV];
            wire signed [DATA_W-1:0] in_data = (st == 0) ? cic_out_reg[ch] : hb_out_reg[ch][PREV];
            // Half-band kernel -1 0 9 16 9 0 -1 over 32: unity DC gain
            wire signed [DATA_W+5:0] acc = 30'(hb_tap_reg[ch][st][3]) * 30'sd16
               + (30'(hb_tap_reg[ch][st][2]) + 30'(hb_tap_reg[ch][st][4])) * 30'sd9
               - 30'(hb_tap_reg[ch][st][0]) - 30'(hb_tap_reg[ch][st][6]);
            wire signed [DATA_W+5:0] acc_sh = acc >>> 5;

            always_ff @(posedge core_clk) begin
               if (srst) begin
                  hb_tap_reg[ch][st][0] <= '0;
                  hb_phase_reg[ch][st] <= 1'b0;
                  hb_valid_reg[ch][st] <= 1'b0;
                  hb_out_reg[ch][st] <= '0;
               end else begin
                  hb_valid_reg[ch][st] <= 1'b0;
                  if (in_valid) begin
                     hb_tap_reg[ch][st][0] <= in_data;
                     hb_phase_reg[ch][st] <= ~hb_phase_reg[ch][st];
                     if (hb_phase_reg[ch][st]) begin
                        hb_out_reg[ch][st] <= DATA_W'(acc_sh); // [RULE10]
                        hb_valid_reg[ch][st] <= 1'b1;
                     end
                  end
               end
            end
            for (k = 1; k < HB_TAPS; k++) begin : g_tap
               always_ff @(posedge core_clk) begin
                  if (srst) begin
                     hb_tap_reg[ch][st][k] <= '0;
                  end else if (in_valid) begin
                     hb_tap_reg[ch][st][k] <= hb_tap_reg[ch][st][k-1];
                  end
               end
            end
         end
      end
   endgenerate

   // Gain, DC-gain trim and high-pass, one pass per frame for both channels
   localparam int EXT_W = DATA_W + 4;
   localparam logic signed [EXT_W-1:0] SAT_MAX = EXT_W'((2 ** (DATA_W - 1)) - 1);
   localparam logic signed [EXT_W-1:0] SAT_MIN = -EXT_W'(2 ** (DATA_W - 1));
   wire dec_valid = hb_valid_reg[0][HB_STAGES-1];
   logic signed [EXT_W-1:0] hp_xprev_reg [2];
   logic signed [EXT_W-1:0] hp_y_reg [2];
   logic [WORD_LEN-1:0] word_reg [2];
   logic pend_reg;

   function automatic logic signed [EXT_W-1:0] sat(input logic signed [EXT_W-1:0] v);
      sat = (v > SAT_MAX) ? SAT_MAX : ((v < SAT_MIN) ? SAT_MIN : v);
   endfunction

   generate
      for (ch = 0; ch < 2; ch++) begin : g_post
         wire signed [EXT_W-1:0] raw = EXT_W'(hb_out_reg[ch][HB_STAGES-1]);
         wire signed [EXT_W-1:0] gained = gain_select_pin ? sat(raw <<< 1) : raw; // [RULE7]
         // Scale by 7/8, close to the -1.16 dB overall gain
         wire signed [EXT_W-1:0] trimmed = gained - (gained >>> 3); // [RULE11]
         wire signed [EXT_W-1:0] hp_next = trimmed - hp_xprev_reg[ch] + hp_y_reg[ch]
            - (hp_y_reg[ch] >>> HPF_SHIFT); // [RULE13]
         wire signed [EXT_W-1:0] chosen = hpf_enable ? sat(hp_next) : trimmed; // [RULE12]

         always_ff @(posedge core_clk) begin
            if (srst) begin
               hp_xprev_reg[ch] <= '0;
               hp_y_reg[ch] <= '0;
               word_reg[ch] <= '0;
            end else if (dec_valid) begin
               hp_xprev_reg[ch] <= trimmed;
               hp_y_reg[ch] <= hpf_enable ? hp_next : '0;
               word_reg[ch] <= chosen[DATA_W-1 -: WORD_LEN]; // [RULE16]
            end
         end
      end
   endgenerate

   // Pair waits until the buffer takes it; a stall past the next frame overwrites it with the next pair
   aad_stream_if #(.WIDTH(SAMPLE_W)) fill_if ();
   aad_stream_if #(.WIDTH(SAMPLE_W)) drain_if ();
   assign fill_if.valid = pend_reg;
   assign fill_if.data = {word_reg[0], word_reg[1]};

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend_reg <= 1'b0;
      end else if (dec_valid) begin
         pend_reg <= 1'b1;
      end else if (fill_if.ready) begin
         pend_reg <= 1'b0;
      end
   end

   aad_pair_buf #(.DEPTH(BUF_DEPTH)) u_buf (
      .core_clk(core_clk),
      .srst(srst),
      .fill(fill_if.snk),
      .drain(drain_if.src)
   );

   // Serial port: edges of the host's bit clock and word select
   logic bck_d_reg;
   logic ws_d_reg;
   logic [FRAME_CNT_W-1:0] frame_cnt_reg;
   logic muted_reg;
   logic [WORD_LEN-1:0] shift_reg;
   logic [WORD_LEN-1:0] right_hold_reg;
   logic [4:0] bits_left_reg;
   logic i2s_pad_reg;
   wire bck_fall = bck_d_reg && !bck;
   wire ws_edge = bck_fall && (ws != ws_d_reg); // [RULE3]
   wire left_start = ws_edge && (fmt_i2s ? !ws : ws); // [RULE15]
   wire [FRAME_CNT_W-1:0] mute_len = hpf_enable ? FRAME_CNT_W'(MUTE_ON_FRAMES) : FRAME_CNT_W'(MUTE_OFF_FRAMES);
   wire have_pair = drain_if.valid;
   wire [WORD_LEN-1:0] new_left = have_pair ? drain_if.data[SAMPLE_W-1 -: WORD_LEN] : '0;
   wire [WORD_LEN-1:0] new_right = have_pair ? drain_if.data[WORD_LEN-1:0] : '0;
   wire [WORD_LEN-1:0] load_word = left_start ? new_left : right_hold_reg;
   assign drain_if.ready = left_start;
   // Mute is decided at the left start itself, so no frame is ever half muted
   wire mute_now = (left_start && muted_reg) ? (frame_cnt_reg < mute_len) : muted_reg;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bck_d_reg <= 1'b0;
         ws_d_reg <= 1'b0;
      end else begin
         bck_d_reg <= bck;
         if (bck_fall) begin
            ws_d_reg <= ws;
         end
      end
   end

   // Output stays low until the filters have settled after reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         frame_cnt_reg <= '0;
         muted_reg <= 1'b1;
      end else if (left_start && muted_reg) begin
         frame_cnt_reg <= frame_cnt_reg + 1'b1;
         muted_reg <= mute_now; // [RULE14]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         shift_reg <= '0;
         right_hold_reg <= '0;
         bits_left_reg <= '0;
         i2s_pad_reg <= 1'b0;
         serial_sample_out <= 1'b0;
      end else if (ws_edge) begin
         if (left_start) begin
            right_hold_reg <= new_right; // [RULE16]
         end
         if (fmt_i2s) begin
            // One bit clock of delay before the MSB in I2S framing
            shift_reg <= load_word;
            bits_left_reg <= 5'(WORD_LEN);
            i2s_pad_reg <= 1'b1;
            serial_sample_out <= 1'b0;
         end else begin
            shift_reg <= load_word << 1;
            bits_left_reg <= 5'(WORD_LEN - 1);
            i2s_pad_reg <= 1'b0;
            serial_sample_out <= load_word[WORD_LEN-1] && !mute_now; // [RULE15]
         end
      end else if (bck_fall) begin
         i2s_pad_reg <= 1'b0;
         if (bits_left_reg != '0) begin
            serial_sample_out <= shift_reg[WORD_LEN-1] && !mute_now; // [RULE14]
            shift_reg <= shift_reg << 1;
            bits_left_reg <= bits_left_reg - 1'b1;
         end else begin
            serial_sample_out <= 1'b0;
         end
      end
   end
endmodule

/* File: verif/aad_host_model.sv */
// Audio host model: makes bit clock and word select, captures serial words.
// Assumes core_clk is the master timing; the bit clock is derived from it.
`timescale 1ns/10ps
module aad_host_model
   import aad_pkg::*;
(
   // Clock, reset, control
   input wire logic core_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic fmt_i2s,
   // Serial port
   output logic bck,
   output logic ws,
   input wire logic sdata,
   // Captured words
   output logic [WORD_LEN-1:0] left_word,
   output logic [WORD_LEN-1:0] right_word,
   output int pairs
);
   logic [2:0] ph;
   logic [4:0] nb;
   int idx;
   logic [WORD_LEN-1:0] sh;
   initial begin
      pairs = 0;
      left_word = '0;
      right_word = '0;
   end
   // Bit clock is core_clk divided by 8, so it stays locked to it
   always @(posedge core_clk) begin
      if (srst) begin
         ph <= 3'h0;
         nb <= 5'h0;
         bck <= 1'b0;
         ws <= 1'b0;
         idx <= 99;
      end else if (run) begin
         ph <= ph + 3'h1;
         if (ph == 3'h4) begin
            bck <= 1'b1;
            if (idx >= int'(fmt_i2s) && idx < WORD_LEN + int'(fmt_i2s)) begin
               sh <= {sh[WORD_LEN-2:0], sdata};
            end
         end
         if (ph == 3'h0) begin
            bck <= 1'b0;
            nb <= nb + 5'h1;
            idx <= idx + 1;
            // 64 bit clocks a frame, word select even, moved on a fall
            if (nb == 5'h1f) begin
               ws <= ~ws;
               idx <= 0;
               if (ws == !fmt_i2s) begin
                  left_word <= sh;
               end else begin
                  right_word <= sh;
                  pairs <= pairs + 1;
               end
            end
         end
      end
   end
endmodule

/* File: verif/aad_decimator_asserts.sv */
// Checker for serial output timing, mute and word framing.
// Assumes bit clock levels last at least two core_clk cycles.
`timescale 1ns/10ps
module aad_decimator_asserts
   import aad_pkg::*;
#(
   parameter int MUTE_OFF_FRAMES = MUTE_FRAMES_DC_OFF,
   parameter int MUTE_ON_FRAMES = MUTE_FRAMES_DC_ON
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Observed pins
   input wire logic hpf_enable,
   input wire logic fmt_i2s,
   input wire logic bck,
   input wire logic ws,
   input wire logic serial_sample_out
);
   logic bck_q;
   logic ws_f;
   logic [7:0] idx;
   int starts;
   wire fall = bck_q & ~bck;
   wire ws_edge = fall & (ws != ws_f);
   wire left_start = ws_edge & (ws ^ fmt_i2s);
   wire [7:0] cur = ws_edge ? 8'h00 : idx + 8'h01;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bck_q <= 1'b0;
         ws_f <= 1'b0;
         idx <= 8'h00;
         starts <= 0;
      end else begin
         bck_q <= bck;
         if (fall) ws_f <= ws;
         if (fall && idx < 8'hf0) idx <= cur;
         if (left_start) starts <= starts + 1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_rst_low;
      disable iff (1'b0) srst |=> !serial_sample_out;
   endproperty
   property p_post_rst;
      $fell(srst) |-> !serial_sample_out [*2];
   endproperty
   property p_mute_off;
      (!hpf_enable && starts < MUTE_OFF_FRAMES - 1) |-> !serial_sample_out;
   endproperty
   property p_mute_on;
      (hpf_enable && starts < MUTE_ON_FRAMES - 1) |-> !serial_sample_out;
   endproperty
   property p_change;
      $changed(serial_sample_out) |-> ($past(fall) || $past(fall, 2));
   endproperty
   property p_settle;
      fall |-> ##3 $stable(serial_sample_out);
   endproperty
   property p_i2s_lead;
      (ws_edge && fmt_i2s) |-> ##2 !serial_sample_out;
   endproperty
   property p_pad;
      (fall && cur >= WORD_LEN + int'(fmt_i2s)) |-> ##2 !serial_sample_out;
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("output not low in reset");
   a_post_rst: assert property (p_post_rst) else $error("output high after reset");
   a_mute_off: assert property (p_mute_off) else $error("short mute broken");
   a_mute_on: assert property (p_mute_on) else $error("long mute broken");
   a_change: assert property (p_change) else $error("output moved without bit clock fall");
   a_settle: assert property (p_settle) else $error("output not settled after fall");
   a_i2s_lead: assert property (p_i2s_lead) else $error("no leading zero bit");
   a_pad: assert property (p_pad) else $error("bit beyond word length not zero");
   c_left: cover property (left_start && starts > MUTE_OFF_FRAMES);
   c_i2s: cover property (left_start && fmt_i2s);
   c_live: cover property (hpf_enable && serial_sample_out);
endmodule
bind aad_decimator aad_decimator_asserts #(.MUTE_OFF_FRAMES(MUTE_OFF_FRAMES), .MUTE_ON_FRAMES(MUTE_ON_FRAMES))
   chk_u (.core_clk(core_clk), .srst(srst), .hpf_enable(hpf_enable), .fmt_i2s(fmt_i2s), .bck(bck), .ws(ws),
   .serial_sample_out(serial_sample_out));

/* File: verif/audio_adc_decimator_bench.sv */
// Bench for the decimator: bitstream stimulus, host model, word checks.
// Assumes short mute parameters so the run stays brief.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module audio_adc_decimator_bench
   import aad_pkg::*;
;
   localparam int M_OFF = 4;
   localparam int M_ON = 8;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic strobe = 1'b0;
   logic mbit = 1'b0;
   logic gain = 1'b0;
   logic hpf = 1'b0;
   logic fmt = 1'b0;
   logic run = 1'b0;
   logic [3:0] sc = 4'h0;
   logic [1:0] dens = 2'h3;
   wire bck;
   wire ws;
   wire sdo;
   logic [WORD_LEN-1:0] lw;
   logic [WORD_LEN-1:0] rw;
   int pairs;
   int miscompares = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   // One strobe per 4 cycles gives 128 bits per 512-cycle frame
   always @(posedge clk) begin
      sc <= sc + 4'h1;
      strobe <= (sc[1:0] == 2'h0);
      mbit <= (sc[3:2] < dens);
   end
   aad_decimator #(.MUTE_OFF_FRAMES(M_OFF), .MUTE_ON_FRAMES(M_ON)) dut_u (.core_clk(clk), .srst(srst),
      .mod_strobe(strobe), .mod_bit_left(mbit), .mod_bit_right(mbit), .gain_select_pin(gain),
      .hpf_enable(hpf), .fmt_i2s(fmt), .bck(bck), .ws(ws), .serial_sample_out(sdo));
   aad_host_model host_u (.core_clk(clk), .srst(srst), .run(run), .fmt_i2s(fmt), .bck(bck), .ws(ws),
      .sdata(sdo), .left_word(lw), .right_word(rw), .pairs(pairs));
   task automatic summarize;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_pairs(input int n);
      int t;
      int lim;
      t = pairs + n;
      lim = 0;
      while (pairs < t && lim < n * 1200) begin
         @(posedge clk);
         lim++;
      end
      if (pairs < t) begin
         miscompares++;
         $display("ERROR %0t: serial words stopped", $time);
         summarize();
      end
   endtask
   // Reset with given controls, check the muted words, return the settled word
   task automatic t_run(input logic h, input logic f, input logic g, input int nm, output logic [WORD_LEN-1:0] w);
      hpf <= h;
      fmt <= f;
      gain <= g;
      run <= 1'b1;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      wait_pairs(1);
      repeat (nm - 1) begin
         wait_pairs(1);
         `CHK(lw, {WORD_LEN{1'b0}})
         `CHK(rw, {WORD_LEN{1'b0}})
      end
      wait_pairs(6);
      `CHK(lw, rw)
      `CHK(lw[WORD_LEN-1] | (lw == '0), 1'b0)
      w = lw;
   endtask
   // Host stalls while bitstream keeps coming; words must stay whole
   task automatic t_stall(input logic [WORD_LEN-1:0] w0);
      run <= 1'b0;
      repeat (3000) @(posedge clk);
      run <= 1'b1;
      wait_pairs(3);
      `CHK(lw, w0)
      `CHK(rw, w0)
   endtask
   // A step down to zero mean must undershoot when DC removal is on
   task automatic t_hpf;
      logic [WORD_LEN-1:0] w;
      t_run(1'b1, 1'b0, 1'b0, M_ON, w);
      dens <= 2'h2;
      wait_pairs(6);
      `CHK(lw[WORD_LEN-1], 1'b1)
      `CHK(lw, rw)
      dens <= 2'h3;
   endtask
   initial begin
      logic [WORD_LEN-1:0] w0;
      logic [WORD_LEN-1:0] w1;
      logic [WORD_LEN-1:0] wi;
      int d;
      t_run(1'b0, 1'b0, 1'b0, M_OFF, w0);
      t_stall(w0);
      t_run(1'b0, 1'b0, 1'b1, M_OFF, w1);
      d = int'(w1) - 2 * int'(w0);
      `CHK(d < 8 && d > -8, 1'b1)
      t_run(1'b0, 1'b1, 1'b0, M_OFF, wi);
      `CHK(wi, w0)
      t_hpf();
      summarize();
   end
endmodule
